// *** core/pmc_defs.svh ***
/*
 Constants for the power mode controller: register offsets, field positions,
 reset values and timing counts. Included by the package and the core module.
*/
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_ADDR_CLK      4'h0
`define PMC_ADDR_OSC      4'h1
`define PMC_ADDR_STATUS   4'h2
`define PMC_ADDR_WAKE_EN  4'h3
`define PMC_ADDR_WDT      4'h4
`define PMC_ADDR_MODE     4'h5

`define PMC_CLK_RST       8'h20
`define PMC_OSC_RST       8'h01
`define PMC_WDT_RST       8'h03

`define PMC_SEL_SUB       3'h7
`define PMC_SEL_LSB       5
`define PMC_FKEEP_BIT     1
`define PMC_SKEEP_BIT     0
`define PMC_FSTABLE_BIT   1
`define PMC_FEN_BIT       0
`define PMC_PDF_BIT       0
`define PMC_TO_BIT        1

`define PMC_FAST_START_NS 16000
`define PMC_CLK_NS        20
`define PMC_SLOW_SYNC     8'h04

`define PMC_PORT_W        24
`define PMC_WDT_W         18
`endif

// *** core/pmc_pkg.sv ***
/*
 Types shared by the power mode controller: mode enumeration and state record.
 Assumes pmc_defs.svh is found on the include path.
*/
`include "pmc_defs.svh"
`default_nettype none
package pmc_pkg;

  // One-hot operating modes
  typedef enum logic [5:0] {
    PMC_FAST   = 6'h01,
    PMC_SLOW   = 6'h02,
    PMC_SLEEP  = 6'h04,
    PMC_IDLE_S = 6'h08,
    PMC_IDLE_B = 6'h10,
    PMC_IDLE_F = 6'h20
  } pmc_mode_type;

  // Every flip-flop of the core
  typedef struct packed {
    pmc_mode_type           mode;
    logic [2:0]             sys_clk_sel;
    logic                   fast_osc_keep_on_stop;
    logic                   slow_osc_keep_on_stop;
    logic                   fast_osc_enable;
    logic                   fast_osc_stable_flag;
    logic [15:0]            fast_cnt;
    logic [7:0]             slow_cnt;
    logic                   power_down_flag;
    logic                   wdt_timeout_flag;
    logic [`PMC_PORT_W-1:0] pin_wake_enable;
    logic [`PMC_PORT_W-1:0] pin_last;
    logic [2:0]             wdt_period_sel;
    logic [`PMC_WDT_W-1:0]  wdt_cnt;
    logic                   slow_rc_osc_last;
    logic [3:0]             wake_cause;
    logic                   resume_pulse;
    logic                   irq_vector_pulse;
    logic                   restart_pulse;
    logic                   waking;
    logic [7:0]             rdata;
  } pmc_state_type;

  // Wake-up report to the core
  typedef struct packed {
    logic resume;
    logic irq_vector;
    logic wdt_restart;
  } pmc_wake_type;

endpackage
`default_nettype wire

// *** core/pmc_power_mode_controller.sv ***
/*
 Power mode controller: system clock select, stop-instruction sleep and idle
 modes, power-down and time-out flags, pin/interrupt/watchdog wake-up and a
 watchdog counter fed from the slow RC clock.
 Assumes the slow RC clock arrives as a level sampled on clk_in, the slow oscillator
 ready level comes from the analog block (fast stability is timed here), and the core gives one-cycle pulses.
*/
// Our own choices: the plain strobed port and the register addresses.
`include "pmc_defs.svh"
`default_nettype none
module pmc_power_mode_controller #(
  parameter int PORT_W   = `PMC_PORT_W,
  parameter int START_NS = `PMC_FAST_START_NS
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Register port
  input  wire logic [3:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  // Processor core
  input  wire logic              stop_instr_in,
  input  wire logic              wdt_clear_instr_in,
  input  wire logic              irq_req_in,
  input  wire logic              irq_pending_before_in,
  input  wire logic              irq_enabled_in,
  input  wire logic              stack_full_in,
  input  wire logic              wdt_enable_in,
  output logic                   cpu_run_out,
  output pmc_pkg::pmc_wake_type  wake_out,
  // Clock tree and oscillators
  input  wire logic              slow_rc_osc_in,
  input  wire logic              slow_osc_ready_in,
  output logic                   fast_osc_on_out,
  output logic                   sub_clk_on_out,
  output logic                   sys_on_sub_out,
  output logic [2:0]             fast_div_log2_out,
  // Port pins
  input  wire logic [PORT_W-1:0] pins_in
);

  localparam int FAST_CYC_I = (START_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;
  localparam logic [15:0] FAST_CYC = 16'(FAST_CYC_I);

  pmc_pkg::pmc_state_type s_r;
  pmc_pkg::pmc_state_type s_nxt;
  logic                   standby;
  logic                   pin_fall;
  logic                   wdt_tick;
  logic                   wdt_ovf;
  logic [`PMC_WDT_W-1:0]  wdt_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog period limit from the period select
  always_comb begin
    case (s_r.wdt_period_sel)
      3'h0:    wdt_lim = 18'h000FF;
      3'h1:    wdt_lim = 18'h003FF;
      3'h2:    wdt_lim = 18'h00FFF;
      3'h3:    wdt_lim = 18'h03FFF;
      3'h4:    wdt_lim = 18'h07FFF;
      3'h5:    wdt_lim = 18'h0FFFF;
      3'h6:    wdt_lim = 18'h1FFFF;
      default: wdt_lim = 18'h3FFFF;
    endcase
  end

  // Shared decode of the current state
  assign standby  = !(s_r.mode inside {pmc_pkg::PMC_FAST, pmc_pkg::PMC_SLOW});
  assign pin_fall = |(s_r.pin_last & ~pins_in[PORT_W-1:0] & s_r.pin_wake_enable);
  assign wdt_tick = slow_rc_osc_in & ~s_r.slow_rc_osc_last; // Rising edge of slow RC
  assign wdt_ovf  = wdt_enable_in && wdt_tick && (s_r.wdt_cnt == wdt_lim);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt                  = s_r;
    s_nxt.pin_last         = pins_in;
    s_nxt.slow_rc_osc_last        = slow_rc_osc_in;
    s_nxt.resume_pulse     = 1'b0;
    s_nxt.irq_vector_pulse = 1'b0;
    s_nxt.restart_pulse    = 1'b0;

    // Register writes; in standby the core is halted so nothing arrives
    if (wr_in) begin
      case (addr_in)
        `PMC_ADDR_CLK: begin
          s_nxt.sys_clk_sel           = wdata_in[`PMC_SEL_LSB+2:`PMC_SEL_LSB];
          s_nxt.fast_osc_keep_on_stop = wdata_in[`PMC_FKEEP_BIT];
          s_nxt.slow_osc_keep_on_stop = wdata_in[`PMC_SKEEP_BIT];
        end
        `PMC_ADDR_OSC: begin
          s_nxt.fast_osc_enable = wdata_in[`PMC_FEN_BIT];
          if (wdata_in[`PMC_FEN_BIT] && !s_r.fast_osc_enable) begin
            s_nxt.fast_osc_stable_flag = 1'b0;
            s_nxt.fast_cnt             = 16'h0000;
          end
        end
        `PMC_ADDR_WAKE_EN: s_nxt.pin_wake_enable[7:0] = wdata_in;
        `PMC_ADDR_WDT:     s_nxt.wdt_period_sel = wdata_in[2:0];
        `PMC_ADDR_MODE:    s_nxt.pin_wake_enable[PORT_W-1:8] = {wdata_in, wdata_in} >> (16 - (PORT_W - 8));
        default: ;
      endcase
    end

    // Fast oscillator start-up timer, counts only while powered
    if (fast_osc_on_out && !s_nxt.fast_osc_stable_flag && s_nxt.fast_cnt == s_r.fast_cnt) begin
      if (s_r.fast_cnt >= FAST_CYC - 16'h0001)
        s_nxt.fast_osc_stable_flag = 1'b1;
      else
        s_nxt.fast_cnt = s_r.fast_cnt + 16'h0001;
    end
    if (!fast_osc_on_out) begin
      s_nxt.fast_osc_stable_flag = 1'b0;
      s_nxt.fast_cnt             = 16'h0000;
    end

    // Slow oscillator qualification for the slow switch
    if (!slow_osc_ready_in)
      s_nxt.slow_cnt = 8'h00;
    else if (s_r.slow_cnt != `PMC_SLOW_SYNC)
      s_nxt.slow_cnt = s_r.slow_cnt + 8'h01;

    // Watchdog counting on slow RC edges
    if (wdt_enable_in && wdt_tick)
      s_nxt.wdt_cnt = wdt_ovf ? '0 : s_r.wdt_cnt + 18'h00001;
    if (!wdt_enable_in)
      s_nxt.wdt_cnt = '0;
    if (wdt_clear_instr_in) begin
      s_nxt.wdt_cnt         = '0;
      s_nxt.power_down_flag = 1'b0;
    end

    // Mode machine
    case (s_r.mode)
      pmc_pkg::PMC_FAST: begin
        if (s_r.sys_clk_sel == `PMC_SEL_SUB && s_r.slow_cnt == `PMC_SLOW_SYNC)
          s_nxt.mode = pmc_pkg::PMC_SLOW;
      end
      pmc_pkg::PMC_SLOW: begin
        if (s_r.sys_clk_sel != `PMC_SEL_SUB && s_r.fast_osc_stable_flag)
          s_nxt.mode = pmc_pkg::PMC_FAST;
      end
      default: begin
        // Wake sources; an interrupt already pending at entry is masked
        // Only the first cause is kept, so a later pin edge cannot hide a watchdog wake
        if (!s_r.waking) begin
          if (wdt_ovf) begin
            s_nxt.wake_cause       = 4'h4;
            s_nxt.wdt_timeout_flag = 1'b1;
          end else if (pin_fall) begin
            s_nxt.wake_cause = 4'h1;
          end else if (irq_req_in && !irq_pending_before_in) begin
            s_nxt.wake_cause = (irq_enabled_in && !stack_full_in) ? 4'h2 : 4'h8;
          end
        end
        if (s_nxt.wake_cause != 4'h0)
          s_nxt.waking = 1'b1;
        // Original oscillator must be stable before execution resumes
        if (s_r.waking && (s_r.sys_clk_sel == `PMC_SEL_SUB ? s_r.slow_cnt == `PMC_SLOW_SYNC
                                                           : s_r.fast_osc_stable_flag)) begin
          s_nxt.mode             = (s_r.sys_clk_sel == `PMC_SEL_SUB) ? pmc_pkg::PMC_SLOW : pmc_pkg::PMC_FAST;
          s_nxt.waking           = 1'b0;
          s_nxt.wake_cause       = 4'h0;
          s_nxt.resume_pulse     = s_r.wake_cause[0] | s_r.wake_cause[3];
          s_nxt.irq_vector_pulse = s_r.wake_cause[1];
          s_nxt.restart_pulse    = s_r.wake_cause[2];
        end
      end
    endcase

    // Stop instruction picks the standby mode from keep bits sampled now
    if (stop_instr_in && !standby) begin
      case ({s_nxt.fast_osc_keep_on_stop, s_nxt.slow_osc_keep_on_stop})
        2'b00:   s_nxt.mode = pmc_pkg::PMC_SLEEP;
        2'b01:   s_nxt.mode = pmc_pkg::PMC_IDLE_S;
        2'b11:   s_nxt.mode = pmc_pkg::PMC_IDLE_B;
        default: s_nxt.mode = pmc_pkg::PMC_IDLE_F;
      endcase
      s_nxt.power_down_flag  = 1'b1;
      s_nxt.wdt_timeout_flag = 1'b0;
      s_nxt.wdt_cnt          = '0;
      s_nxt.wake_cause       = 4'h0;
      s_nxt.waking           = 1'b0;
    end

    // Read data, valid the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `PMC_ADDR_CLK:     s_nxt.rdata = {s_r.sys_clk_sel, 3'h0, s_r.fast_osc_keep_on_stop,
                                          s_r.slow_osc_keep_on_stop};
        `PMC_ADDR_OSC:     s_nxt.rdata = {6'h00, s_r.fast_osc_stable_flag, s_r.fast_osc_enable};
        `PMC_ADDR_STATUS:  s_nxt.rdata = {6'h00, s_r.wdt_timeout_flag, s_r.power_down_flag};
        `PMC_ADDR_WAKE_EN: s_nxt.rdata = s_r.pin_wake_enable[7:0];
        `PMC_ADDR_WDT:     s_nxt.rdata = {5'h00, s_r.wdt_period_sel};
        `PMC_ADDR_MODE:    s_nxt.rdata = {2'h0, s_r.mode};
        default:           s_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; power-up clears the power-down flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r                 <= '0;
      s_r.mode            <= pmc_pkg::PMC_FAST;
      s_r.sys_clk_sel     <= 3'h1;
      s_r.fast_osc_enable <= 1'b1;
      s_r.wdt_period_sel  <= 3'h3;
      s_r.slow_cnt        <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; clocks gated per mode, core held in standby
  assign rdata_out            = s_r.rdata;
  assign cpu_run_out          = !standby;
  assign wake_out.resume      = s_r.resume_pulse;
  assign wake_out.irq_vector  = s_r.irq_vector_pulse;
  assign wake_out.wdt_restart = s_r.restart_pulse;
  assign fast_osc_on_out = (s_r.mode == pmc_pkg::PMC_FAST) || s_r.waking
                         || (s_r.mode inside {pmc_pkg::PMC_IDLE_B, pmc_pkg::PMC_IDLE_F})
                         // A return to fast powers the oscillator even if it was off in slow mode
                         || (s_r.mode == pmc_pkg::PMC_SLOW
                             && (s_r.fast_osc_enable || s_r.sys_clk_sel != `PMC_SEL_SUB));
  assign sub_clk_on_out  = s_r.mode inside {pmc_pkg::PMC_FAST, pmc_pkg::PMC_SLOW,
                                            pmc_pkg::PMC_IDLE_S, pmc_pkg::PMC_IDLE_B};
  assign sys_on_sub_out    = (s_r.mode == pmc_pkg::PMC_SLOW);
  assign fast_div_log2_out = (s_r.sys_clk_sel == `PMC_SEL_SUB) ? 3'h0 : s_r.sys_clk_sel;

endmodule
`default_nettype wire

// *** tb/pmc_osc_model.sv ***
/*
 Slow RC oscillator model: a free-running slow clock and its stable level.
 Assumes it shares the bench clock and reset.
*/
`default_nettype none
module pmc_osc_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Oscillator outputs
  output logic      slow_rc_osc_out,
  output logic      slow_osc_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_r;
  logic       rdy_r;
  // Ready comes late on purpose so a slow switch must wait for it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 6'h00;
      rdy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      rdy_r <= rdy_r | (cnt_r == 6'h3F);
    end
  end
  // Slow clock runs free, four system cycles a period
  assign slow_rc_osc_out    = cnt_r[1];
  assign slow_osc_ready_out = rdy_r;
endmodule
`default_nettype wire

// *** tb/pmc_checker.sv ***
/*
 Assertions on the ports of the power mode controller.
 Assumes keep bits and low wake enables are only changed by register writes.
*/
`default_nettype none
module pmc_checker #(
  parameter int PORT_W = 24
) (
  // Clock and reset
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  // Register and core side
  input wire logic [3:0]            addr_in,
  input wire logic [7:0]            wdata_in,
  input wire logic                  wr_in,
  input wire logic                  stop_instr_in,
  input wire logic                  cpu_run_out,
  input wire pmc_pkg::pmc_wake_type wake_out,
  // Clock tree and pins
  input wire logic                  slow_osc_ready_in,
  input wire logic                  fast_osc_on_out,
  input wire logic                  sub_clk_on_out,
  input wire logic                  sys_on_sub_out,
  input wire logic [2:0]            fast_div_log2_out,
  input wire logic [PORT_W-1:0]     pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] keep_r;
  logic [7:0] wen_r;
  logic       stp;
  ////////////////////////////////////////////////////////////
  // Shadow copies, since the registers are not visible here
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      keep_r <= 2'h0;
      wen_r  <= 8'h00;
    end else if (wr_in && addr_in == 4'h0) begin
      keep_r <= wdata_in[1:0];
    end else if (wr_in && addr_in == 4'h3) begin
      wen_r <= wdata_in;
    end
  end
  // A stop only counts while running
  assign stp = stop_instr_in && cpu_run_out;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_halt; stp |=> !cpu_run_out; endproperty
  a_halt: assert property (p_halt) else $error("stop did not halt");
  property p_sleep; stp && keep_r == 2'h0 |=> !fast_osc_on_out && !sub_clk_on_out; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_idle_s; stp && keep_r == 2'h1 |=> !fast_osc_on_out && sub_clk_on_out; endproperty
  a_idle_s: assert property (p_idle_s) else $error("slow idle clocks wrong");
  property p_idle_b; stp && keep_r == 2'h3 |=> fast_osc_on_out && sub_clk_on_out; endproperty
  a_idle_b: assert property (p_idle_b) else $error("dual idle clocks wrong");
  property p_idle_f; stp && keep_r == 2'h2 |=> fast_osc_on_out && !sub_clk_on_out; endproperty
  a_idle_f: assert property (p_idle_f) else $error("fast idle clocks wrong");
  property p_div; wr_in && addr_in == 4'h0 && wdata_in[7:5] != 3'h7 && !sys_on_sub_out
    |=> fast_div_log2_out == $past(wdata_in[7:5]); endproperty
  a_div: assert property (p_div) else $error("divider wrong");
  property p_slow_wait; !slow_osc_ready_in && !sys_on_sub_out |=> !sys_on_sub_out; endproperty
  a_slow_wait: assert property (p_slow_wait) else $error("sub clock used unstable");
  property p_back; sys_on_sub_out && wr_in && addr_in == 4'h0 && wdata_in[7:5] != 3'h7
    |-> ##[1:1000] !sys_on_sub_out; endproperty
  a_back: assert property (p_back) else $error("no return to fast");
  property p_pin; !cpu_run_out && |(wen_r & $past(pins_in[7:0]) & ~pins_in[7:0])
    |-> ##[1:1000] |wake_out; endproperty
  a_pin: assert property (p_pin) else $error("pin edge did not wake");
  property p_onehot; $onehot0(wake_out); endproperty
  a_onehot: assert property (p_onehot) else $error("two wake causes");
  property p_pulse; wake_out.resume |=> !wake_out.resume ##1 cpu_run_out; endproperty
  a_pulse: assert property (p_pulse) else $error("resume pulse wrong");
endmodule
bind pmc_power_mode_controller pmc_checker #(.PORT_W(PORT_W)) chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .stop_instr_in(stop_instr_in), .cpu_run_out(cpu_run_out),
  .wake_out(wake_out), .slow_osc_ready_in(slow_osc_ready_in),
  .fast_osc_on_out(fast_osc_on_out), .sub_clk_on_out(sub_clk_on_out),
  .sys_on_sub_out(sys_on_sub_out), .fast_div_log2_out(fast_div_log2_out), .pins_in(pins_in));
`default_nettype wire

// *** tb/test_power_mode_controller.sv ***
/*
 Self-checking bench for the power mode controller.
 Assumes the oscillator model and checker are compiled before it.
*/
`default_nettype none
module test_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, stop = 1'b0, wclr = 1'b0;
  logic irq = 1'b0, irq_old = 1'b0, irq_en = 1'b1, stk_full = 1'b0, wdt_en = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata, d;
  logic [23:0] pins = 24'hFFFFFF;
  logic        run, f_on, s_on, on_sub, slow_rc_osc, lrdy;
  logic [2:0]  div;
  pmc_pkg::pmc_wake_type wake;
  pmc_pkg::pmc_mode_type exp_mode [4] = '{pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_IDLE_S,
                                          pmc_pkg::PMC_IDLE_F, pmc_pkg::PMC_IDLE_B};
  int err_count = 0, checked = 0, i, n;
  // Short fast start-up keeps wake-ups quick
  always #10 clk_in = ~clk_in;
  pmc_osc_model osc_u (.clk_in(clk_in), .rst_in(rst_in), .slow_rc_osc_out(slow_rc_osc), .slow_osc_ready_out(lrdy));
  pmc_power_mode_controller #(.START_NS(200)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .stop_instr_in(stop), .wdt_clear_instr_in(wclr), .irq_req_in(irq),
    .irq_pending_before_in(irq_old), .irq_enabled_in(irq_en), .stack_full_in(stk_full),
    .wdt_enable_in(wdt_en), .cpu_run_out(run), .wake_out(wake), .slow_rc_osc_in(slow_rc_osc),
    .slow_osc_ready_in(lrdy), .fast_osc_on_out(f_on), .sub_clk_on_out(s_on),
    .sys_on_sub_out(on_sub), .fast_div_log2_out(div), .pins_in(pins));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bus cycles: strobe for one cycle, read data the cycle after
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    v = rdata;
  endtask
  task automatic halt_cpu;
    @(posedge clk_in);
    stop <= 1'b1;
    @(posedge clk_in);
    stop <= 1'b0;
    @(negedge clk_in);
  endtask
  // Bounded wait for any wake pulse
  task automatic wait_wake(output int cnt);
    for (cnt = 0; cnt < 3000; cnt++) begin
      @(negedge clk_in);
      if (wake !== 3'h0) break;
    end
    if (cnt == 3000) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(4'h0, d); chk("clk_reg", d, 8'h20);
    rd_reg(4'h4, d); chk("wdt_sel", d, 8'h03);
    rd_reg(4'h2, d); chk("status", d, 8'h00);
    rd_reg(4'hF, d); chk("unmapped", d, 8'h00);
    for (i = 0; i < 100; i++) begin
      rd_reg(4'h1, d);
      if (d[1] === 1'b1) break;
    end
    chk("fast_stable", d, 8'h03);
    for (i = 0; i < 7; i++) begin
      wr_reg(4'h0, {i[2:0], 5'h00});
      @(negedge clk_in);
      chk("div", {5'h00, div}, {5'h00, i[2:0]});
    end
    wr_reg(4'h0, 8'hE0);
    for (i = 0; i < 200 && on_sub !== 1'b1; i++) @(negedge clk_in);
    chk("on_sub", {7'h00, on_sub}, 8'h01);
    // Fast oscillator off in slow mode, so the return must restart it
    wr_reg(4'h1, 8'h00);
    rd_reg(4'h1, d); chk("fast_off", d, 8'h00);
    wr_reg(4'h0, 8'h40);
    for (i = 0; i < 900 && on_sub !== 1'b0; i++) @(negedge clk_in);
    chk("div_back", {4'h0, on_sub, div}, 8'h02);
    rd_reg(4'h1, d); chk("fast_back", d, 8'h02);
    wr_reg(4'h3, 8'h01);
    // Every keep-bit combination, woken by an enabled pin
    for (i = 0; i < 4; i++) begin
      wr_reg(4'h0, {6'h00, i[1:0]});
      halt_cpu();
      chk("run", {7'h00, run}, 8'h00);
      rd_reg(4'h5, d); chk("mode", d, {2'h0, exp_mode[i]});
      rd_reg(4'h2, d); chk("status", d, 8'h01);
      @(posedge clk_in) pins[0] <= 1'b0;
      wait_wake(n); chk("pin_wake", {5'h00, wake}, 8'h04);
      @(posedge clk_in) pins[0] <= 1'b1;
      @(negedge clk_in) chk("run", {7'h00, run}, 8'h01);
    end
    // Disabled pin and an old request must not wake
    wr_reg(4'h0, 8'h00);
    @(posedge clk_in) {irq, irq_old} <= 2'h3;
    halt_cpu();
    @(posedge clk_in) pins[1] <= 1'b0;
    repeat (40) @(negedge clk_in);
    chk("asleep", {7'h00, run}, 8'h00);
    @(posedge clk_in) irq_old <= 1'b0;
    wait_wake(n); chk("irq_wake", {5'h00, wake}, 8'h02);
    @(posedge clk_in) {irq, stk_full, pins[1]} <= 3'h3;
    halt_cpu();
    @(posedge clk_in) irq <= 1'b1;
    wait_wake(n); chk("full_wake", {5'h00, wake}, 8'h04);
    @(posedge clk_in) {irq, stk_full} <= 2'h0;
    // Shortest watchdog period wakes with the time-out flag
    wr_reg(4'h4, 8'h00);
    @(posedge clk_in) wdt_en <= 1'b1;
    halt_cpu();
    wait_wake(n); chk("wdt_wake", {5'h00, wake}, 8'h01);
    chk("wdt_len", (n >= 1000 && n <= 1100) ? 8'h01 : 8'h00, 8'h01);
    rd_reg(4'h2, d); chk("status", d, 8'h03);
    @(posedge clk_in) {wdt_en, wclr} <= 2'h1;
    @(posedge clk_in) wclr <= 1'b0;
    rd_reg(4'h2, d); chk("status", d, 8'h02);
    end_sim();
  end
endmodule
`default_nettype wire
